// ===== mcc_pkg.sv
// Shared constants and types for the multi-channel capture unit
package mcc_pkg;

	localparam int          NUM_CHAN       = 16;
	localparam int          CNT_W          = 16;
	localparam int          STAGGER_SLOTS  = 8;
	localparam int          PRESC_W        = 8;
	localparam logic [15:0] CNT_MAX        = 16'hFFFF;
	localparam logic [15:0] RELOAD_RST     = 16'h0000;
	localparam logic [15:0] COUNT_RST      = 16'h0000;
	localparam logic [2:0]  SLOT_LAST      = 3'h7;
	localparam logic [2:0]  PAIR_MASK      = 3'h7;
	localparam int          DBL_PAIR_OFS   = 8;

	// Capture edge selection field
	localparam logic [1:0]  EDGE_RISE      = 2'h1;
	localparam logic [1:0]  EDGE_FALL      = 2'h2;

	typedef enum logic [1:0] {
		MCC_SRC_PRESC  = 2'b00,
		MCC_SRC_GP_OVF = 2'b01,
		MCC_SRC_EXT    = 2'b10
	} mcc_clk_src_t;

	typedef enum logic [2:0] {
		MCC_CMP_IRQ_MULTI = 3'b000,
		MCC_CMP_TOGGLE    = 3'b001,
		MCC_CMP_IRQ_ONCE  = 3'b010,
		MCC_CMP_SET_CLR   = 3'b011,
		MCC_CMP_DOUBLE    = 3'b100
	} mcc_cmp_mode_t;

	typedef struct packed {
		logic          run;
		mcc_clk_src_t  src;
		logic [2:0]    presc;
	} mcc_tb_cfg_t;

	typedef struct packed {
		logic          capture;
		logic          tsel;
		logic [1:0]    edge_sel;
		mcc_cmp_mode_t cmode;
		logic          single;
	} mcc_chan_cfg_t;

	typedef struct packed {
		logic [15:0]   count;
		logic [15:0]   reload;
		logic [7:0]    presc_cnt;
		logic          ext_q;
		logic          tick;
		logic          ovf;
	} mcc_tb_state_t;

	typedef struct packed {
		logic [15:0][15:0] val;
		logic [15:0]       pin_q;
		logic [15:0]       pin_out;
		logic [15:0]       pin_oe;
		logic [15:0]       irq;
		logic [15:0]       armed;
		logic [15:0]       se_done;
		logic [2:0]        slot;
	} mcc_state_t;

	// Mask of low prescaler bits that must all be set for a tick
	function automatic logic [7:0] presc_mask(input logic [2:0] sel);
		presc_mask = ~(8'hFF << sel);
	endfunction : presc_mask

endpackage : mcc_pkg

// ===== mcc_time_base.sv
// One 16-bit time base with reload register and selectable count source
`timescale 1ns/100ps
module mcc_time_base (
	// Clock and reset
	input  wire logic                 i_mclk,
	input  wire logic                 i_resetn,
	// Configuration
	input  wire mcc_pkg::mcc_tb_cfg_t i_cfg,
	input  wire logic                 i_gp_ovf,
	input  wire logic                 i_ext_cnt,
	input  wire logic                 i_rel_wr,
	input  wire logic [15:0]          i_rel_data,
	// Status
	output logic      [15:0]          o_count,
	output logic                      o_tick,
	output logic                      o_ovf
);

	mcc_pkg::mcc_tb_state_t st;
	mcc_pkg::mcc_tb_state_t next_st;
	logic                   inc;

	always_comb begin
		next_st      = st;
		next_st.tick = 1'b0;
		next_st.ovf  = 1'b0;
		next_st.ext_q = i_ext_cnt;
		next_st.presc_cnt = st.presc_cnt + 8'h01;
		if (i_rel_wr) begin
			next_st.reload = i_rel_data;
		end
		unique case (i_cfg.src)
			mcc_pkg::MCC_SRC_PRESC:  inc = (st.presc_cnt & mcc_pkg::presc_mask(i_cfg.presc))
				== mcc_pkg::presc_mask(i_cfg.presc);
			mcc_pkg::MCC_SRC_GP_OVF: inc = i_gp_ovf;
			mcc_pkg::MCC_SRC_EXT:    inc = i_ext_cnt & ~st.ext_q;
			default:                 inc = 1'b0;
		endcase
		if (i_cfg.run && inc) begin
			next_st.tick = 1'b1;
			if (st.count == mcc_pkg::CNT_MAX) begin
				next_st.count = next_st.reload;
				next_st.ovf   = 1'b1;
			end else begin
				next_st.count = st.count + 16'h0001;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			st <= '{count: mcc_pkg::COUNT_RST, reload: mcc_pkg::RELOAD_RST, default: '0};
		end else begin
			st <= next_st;
		end
	end

	assign o_count = st.count;
	assign o_tick  = st.tick;
	assign o_ovf   = st.ovf;

	property p_reload_on_ovf;
		@(posedge i_mclk) disable iff (!i_resetn)
		(i_cfg.run && inc && st.count == mcc_pkg::CNT_MAX && !i_rel_wr)
			|=> (o_ovf && o_count == $past(st.reload));
	endproperty
	a_reload_on_ovf: assert property (p_reload_on_ovf) else $error("timer not reloaded");

endmodule : mcc_time_base

// ===== mcc_capture_unit.sv
// Sixteen-channel capture/compare unit with two time bases
`timescale 1ns/100ps
// Functional notes
// - Sixteen capture/compare channels, one clock resolution normally.
// - Staggered operation services each channel once every eight clocks.
// - Two independent 16-bit timers with reload registers serve as time bases.
// - Each timer counts on prescaled clock or the shared i_gp_ovf overflow input.
// - An external count input may clock either timer.
// - Each channel picks its timer and capture or compare operation.
// - Each channel owns one pin: capture input or compare output.
// - Qualifying pin edge copies assigned timer count into channel register.
// - Every capture raises that channel's interrupt request.
// - Capture trigger is rising, falling or both edges.
// - Compare channels match against their timer on every count, only in their own slot when staggered.
// - Mode zero: interrupt only, many per period allowed.
// - Mode one: each match toggles the pin, many per period.
// - Mode two: interrupt only, first match per period only.
// - Mode three: pin high on match, low on overflow, once per period.
// - Double register: two channels share a pin, a match on either toggles it, once if both match in the same clock.
// - Single event option limits output to one edge or pulse.
module mcc_capture_unit (
	// Clock and reset
	input  wire logic                             i_mclk,
	input  wire logic                             i_resetn,
	// Time base control
	input  wire mcc_pkg::mcc_tb_cfg_t             i_tb_cfg_a,
	input  wire mcc_pkg::mcc_tb_cfg_t             i_tb_cfg_b,
	input  wire logic                             i_gp_ovf,
	input  wire logic                             i_ext_cnt_a,
	input  wire logic                             i_ext_cnt_b,
	input  wire logic                             i_rel_wr_a,
	input  wire logic                             i_rel_wr_b,
	input  wire logic [15:0]                      i_rel_data,
	// Channel configuration and register writes
	input  wire mcc_pkg::mcc_chan_cfg_t [15:0]    i_chan_cfg,
	input  wire logic                             i_staggered,
	input  wire logic                             i_wr_en,
	input  wire logic [3:0]                       i_wr_chan,
	input  wire logic [15:0]                      i_wr_data,
	// Channel pins
	input  wire logic [15:0]                      i_pin,
	output logic      [15:0]                      o_pin,
	output logic      [15:0]                      o_pin_oe,
	// Status
	output logic      [15:0][15:0]                o_chan_value,
	output logic      [15:0]                      o_irq,
	output logic      [15:0]                      o_count_a,
	output logic      [15:0]                      o_count_b
);

	mcc_pkg::mcc_state_t st;
	mcc_pkg::mcc_state_t next_st;

	logic [15:0] cnt_a;
	logic [15:0] cnt_b;
	logic        tick_a;
	logic        tick_b;
	logic        ovf_a;
	logic        ovf_b;

	// Per-channel decode, kept visible for the checks below
	logic [15:0] act;
	logic [15:0] cap_evt;
	logic [15:0] match;
	logic [15:0] tgl;
	logic [15:0] set_pin;
	logic [15:0] clr_pin;
	logic [15:0] drives;

	mcc_time_base u_tb_a (
		.i_mclk     (i_mclk),
		.i_resetn   (i_resetn),
		.i_cfg      (i_tb_cfg_a),
		.i_gp_ovf   (i_gp_ovf),
		.i_ext_cnt  (i_ext_cnt_a),
		.i_rel_wr   (i_rel_wr_a),
		.i_rel_data (i_rel_data),
		.o_count    (cnt_a),
		.o_tick     (tick_a),
		.o_ovf      (ovf_a)
	);

	mcc_time_base u_tb_b (
		.i_mclk     (i_mclk),
		.i_resetn   (i_resetn),
		.i_cfg      (i_tb_cfg_b),
		.i_gp_ovf   (i_gp_ovf),
		.i_ext_cnt  (i_ext_cnt_b),
		.i_rel_wr   (i_rel_wr_b),
		.i_rel_data (i_rel_data),
		.o_count    (cnt_b),
		.o_tick     (tick_b),
		.o_ovf      (ovf_b)
	);

	function automatic logic [15:0] sel_cnt(input logic t, input logic [15:0] a,
		input logic [15:0] b);
		sel_cnt = t ? b : a;
	endfunction : sel_cnt

	function automatic logic sel_bit(input logic t, input logic a, input logic b);
		sel_bit = t ? b : a;
	endfunction : sel_bit

	always_comb begin
		mcc_pkg::mcc_chan_cfg_t c;
		logic [15:0]            cnt;
		logic                   tk;
		logic                   ov;
		logic                   rise;
		logic                   fall;
		int                     p;
		c       = '0;
		cnt     = '0;
		tk      = 1'b0;
		ov      = 1'b0;
		rise    = 1'b0;
		fall    = 1'b0;
		p       = 0;
		next_st = st;
		next_st.irq = '0;
		act     = '0;
		cap_evt = '0;
		match   = '0;
		tgl     = '0;
		set_pin = '0;
		clr_pin = '0;
		drives  = '0;
		// Stagger slot walks all channels in groups of two per clock
		next_st.slot = (st.slot == mcc_pkg::SLOT_LAST) ? 3'h0 : st.slot + 3'h1;
		for (int i = 0; i < mcc_pkg::NUM_CHAN; i++) begin
			c    = i_chan_cfg[i];
			cnt  = sel_cnt(c.tsel, cnt_a, cnt_b);
			tk   = sel_bit(c.tsel, tick_a, tick_b);
			ov   = sel_bit(c.tsel, ovf_a, ovf_b);
			act[i] = !i_staggered || (st.slot == 3'(i));
			rise = i_pin[i] & ~st.pin_q[i];
			fall = ~i_pin[i] & st.pin_q[i];
			if (act[i]) begin
				next_st.pin_q[i] = i_pin[i];
			end
			if (i_wr_en && i_wr_chan == 4'(i)) begin
				next_st.val[i]     = i_wr_data;
				next_st.se_done[i] = 1'b0;
				next_st.armed[i]   = 1'b1;
			end
			if (c.capture) begin
				// Pin is an input while capturing
				cap_evt[i] = act[i] && ((rise && c.edge_sel[0]) || (fall && c.edge_sel[1]));
				if (cap_evt[i]) begin
					next_st.val[i] = cnt;
					next_st.irq[i] = 1'b1;
				end
			end else begin
				// Overflow re-arms once-per-period modes
				if (ov) begin
					next_st.armed[i] = 1'b1;
					if (c.cmode == mcc_pkg::MCC_CMP_SET_CLR && !st.se_done[i]) begin
						clr_pin[i] = 1'b1;
					end
				end
				match[i] = act[i] && tk && (cnt == st.val[i]) && !st.se_done[i];
				unique case (c.cmode)
					mcc_pkg::MCC_CMP_IRQ_MULTI: begin
						if (match[i]) begin
							next_st.irq[i] = 1'b1;
						end
					end
					mcc_pkg::MCC_CMP_TOGGLE: begin
						drives[i] = 1'b1;
						tgl[i]    = tgl[i] | match[i];
					end
					mcc_pkg::MCC_CMP_IRQ_ONCE: begin
						// Overflow in the same cycle opens a new period
						if (match[i] && (st.armed[i] || ov)) begin
							next_st.irq[i]   = 1'b1;
							next_st.armed[i] = 1'b0;
						end
					end
					mcc_pkg::MCC_CMP_SET_CLR: begin
						drives[i] = 1'b1;
						if (match[i] && (st.armed[i] || ov)) begin
							set_pin[i]       = 1'b1;
							next_st.armed[i] = 1'b0;
						end
					end
					mcc_pkg::MCC_CMP_DOUBLE: begin
						// Pair i and i+8 share the lower channel's pin
						p = i & 7;
						drives[p] = 1'b1;
						tgl[p]    = tgl[p] | match[i];
					end
					default: begin
					end
				endcase
				// Single event: freeze after the first action until rewritten
				if (c.single && match[i]) begin
					next_st.se_done[i] = 1'b1;
				end
			end
		end
		next_st.pin_out = ((st.pin_out ^ tgl) & ~clr_pin) | set_pin;
		next_st.pin_oe  = drives;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			st <= '{armed: 16'hFFFF, default: '0};
		end else begin
			st <= next_st;
		end
	end

	assign o_pin        = st.pin_out;
	assign o_pin_oe     = st.pin_oe;
	assign o_chan_value = st.val;
	assign o_irq        = st.irq;
	assign o_count_a    = cnt_a;
	assign o_count_b    = cnt_b;

	// Checks on channel behaviour
	for (genvar g = 0; g < 16; g++) begin : g_chk
		sequence s_capture;
			i_chan_cfg[g].capture && cap_evt[g];
		endsequence

		sequence s_captured_value(logic [15:0] v);
			o_irq[g] && o_chan_value[g] == v;
		endsequence

		property p_capture_latch;
			logic [15:0] v;
			@(posedge i_mclk) disable iff (!i_resetn)
			(s_capture, v = sel_cnt(i_chan_cfg[g].tsel, cnt_a, cnt_b))
				|=> s_captured_value(v);
		endproperty
		a_capture_latch: assert property (p_capture_latch) else $error("capture lost");

		property p_irq_pulse;
			@(posedge i_mclk) disable iff (!i_resetn)
			o_irq[g] && !cap_evt[g] && !match[g] |=> !o_irq[g];
		endproperty
		a_irq_pulse: assert property (p_irq_pulse) else $error("irq not a pulse");

		property p_edge_qual;
			@(posedge i_mclk) disable iff (!i_resetn)
			cap_evt[g] |-> (i_pin[g] ? i_chan_cfg[g].edge_sel[0] : i_chan_cfg[g].edge_sel[1]);
		endproperty
		a_edge_qual: assert property (p_edge_qual) else $error("bad capture edge");

		property p_toggle;
			@(posedge i_mclk) disable iff (!i_resetn)
			(!i_chan_cfg[g].capture && i_chan_cfg[g].cmode == mcc_pkg::MCC_CMP_TOGGLE
				&& match[g] && !clr_pin[g] && !set_pin[g]
				&& (g >= 8 || !(match[(g + 8) % 16] && i_chan_cfg[(g + 8) % 16].cmode
				== mcc_pkg::MCC_CMP_DOUBLE)))
				|=> o_pin[g] != $past(o_pin[g]);
		endproperty
		a_toggle: assert property (p_toggle) else $error("pin did not toggle");

		property p_set_on_match;
			@(posedge i_mclk) disable iff (!i_resetn)
			set_pin[g] |=> o_pin[g] && o_pin_oe[g];
		endproperty
		a_set_on_match: assert property (p_set_on_match) else $error("pin not set");

		property p_clr_on_ovf;
			@(posedge i_mclk) disable iff (!i_resetn)
			clr_pin[g] && !set_pin[g] |=> !o_pin[g];
		endproperty
		a_clr_on_ovf: assert property (p_clr_on_ovf) else $error("pin not cleared");

		property p_once_per_period;
			@(posedge i_mclk) disable iff (!i_resetn)
			(!i_chan_cfg[g].capture && i_chan_cfg[g].cmode == mcc_pkg::MCC_CMP_IRQ_ONCE
				&& o_irq[g] && !ovf_a && !ovf_b && !i_wr_en)
				|-> !st.armed[g];
		endproperty
		a_once_per_period: assert property (p_once_per_period) else $error("second irq");

		property p_single_freeze;
			@(posedge i_mclk) disable iff (!i_resetn)
			(!i_chan_cfg[g].capture && st.se_done[g]) |=> !o_irq[g];
		endproperty
		a_single_freeze: assert property (p_single_freeze) else $error("event after single");

		property p_stagger_slot;
			@(posedge i_mclk) disable iff (!i_resetn)
			(i_staggered && act[g]) |=> ##7 act[g] || !i_staggered;
		endproperty
		a_stagger_slot: assert property (p_stagger_slot) else $error("stagger slot");

		property p_capture_input;
			@(posedge i_mclk) disable iff (!i_resetn)
			(i_chan_cfg[g].capture && (g >= 8 || i_chan_cfg[(g + 8) % 16].capture
				|| i_chan_cfg[(g + 8) % 16].cmode != mcc_pkg::MCC_CMP_DOUBLE))
				|=> !o_pin_oe[g] || !$past(i_chan_cfg[g].capture);
		endproperty
		a_capture_input: assert property (p_capture_input) else $error("capture pin driven");
	end

endmodule : mcc_capture_unit

// ===== mcc_pin_model.sv
// Pin-side partner: trigger levels, external count input and shared pin levels
`timescale 1ns/100ps
module mcc_pin_model (
	// Clock
	input  wire logic        i_mclk,
	// Device pin drivers
	input  wire logic [15:0] i_pin_out,
	input  wire logic [15:0] i_pin_oe,
	// Levels seen by the device
	output logic      [15:0] o_pin,
	output logic             o_ext_a,
	output logic             o_ext_b
);
	logic [15:0] drv = 16'h0000;

	// Device wins wherever it drives the pin
	assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & drv);
	assign o_ext_b = 1'h0;
	initial o_ext_a = 1'h0;

	task automatic set_pin(input int ch, input logic v);
		@(posedge i_mclk);
		drv[ch] <= v;
	endtask : set_pin

	// Each pulse is one rising count edge
	task automatic ext_pulses(input int n);
		repeat (n) begin
			@(posedge i_mclk);
			o_ext_a <= 1'h1;
			@(posedge i_mclk);
			o_ext_a <= 1'h0;
		end
	endtask : ext_pulses
endmodule : mcc_pin_model

// ===== tb.sv
// Self-checking bench for the multi-channel capture unit
`timescale 1ns/100ps
module tb;
	typedef struct packed {
		logic                   cap;
		logic [1:0]             es;
		logic                   rise;
		mcc_pkg::mcc_cmp_mode_t cm;
		logic                   eirq;
		logic                   epin;
	} mcc_row_t;

	localparam mcc_row_t ROWS [10] = '{
		'{1'h0, 2'h0, 1'h0, mcc_pkg::MCC_CMP_IRQ_MULTI, 1'h1, 1'h0},
		'{1'h0, 2'h0, 1'h0, mcc_pkg::MCC_CMP_TOGGLE, 1'h0, 1'h1},
		'{1'h0, 2'h0, 1'h0, mcc_pkg::MCC_CMP_IRQ_ONCE, 1'h1, 1'h0},
		'{1'h0, 2'h0, 1'h0, mcc_pkg::MCC_CMP_SET_CLR, 1'h0, 1'h1},
		'{1'h1, 2'h1, 1'h1, mcc_pkg::MCC_CMP_IRQ_MULTI, 1'h1, 1'h0},
		'{1'h1, 2'h1, 1'h0, mcc_pkg::MCC_CMP_IRQ_MULTI, 1'h0, 1'h0},
		'{1'h1, 2'h2, 1'h1, mcc_pkg::MCC_CMP_IRQ_MULTI, 1'h0, 1'h0},
		'{1'h1, 2'h2, 1'h0, mcc_pkg::MCC_CMP_IRQ_MULTI, 1'h1, 1'h0},
		'{1'h1, 2'h3, 1'h1, mcc_pkg::MCC_CMP_IRQ_MULTI, 1'h1, 1'h0},
		'{1'h1, 2'h3, 1'h0, mcc_pkg::MCC_CMP_IRQ_MULTI, 1'h1, 1'h0}
	};

	logic                               i_mclk;
	logic                               resetn;
	mcc_pkg::mcc_tb_cfg_t               cfg_a;
	mcc_pkg::mcc_tb_cfg_t               cfg_b;
	logic                               gp_ovf;
	logic                               ext_a;
	logic                               ext_b;
	logic                               rel_wr_b;
	logic                               rel_wr_a;
	logic                               staggered;
	logic [15:0]                        rel_data;
	mcc_pkg::mcc_chan_cfg_t [15:0]      chan_cfg;
	logic                               wr_en;
	logic [3:0]                         wr_chan;
	logic [15:0]                        wr_data;
	logic [15:0]                        pin_in;
	logic [15:0]                        o_pin;
	logic [15:0]                        o_pin_oe;
	logic [15:0][15:0]                  o_chan_value;
	logic [15:0]                        o_irq;
	logic [15:0]                        o_count_a;
	logic [15:0]                        o_count_b;
	int                                 num_errors = 0;
	int                                 checks = 0;
	int                                 cyc = 0;

	mcc_capture_unit mcc_capture_unit_inst (
		.i_mclk(i_mclk), .i_resetn(resetn), .i_tb_cfg_a(cfg_a), .i_tb_cfg_b(cfg_b),
		.i_gp_ovf(gp_ovf), .i_ext_cnt_a(ext_a), .i_ext_cnt_b(ext_b), .i_rel_wr_a(rel_wr_a),
		.i_rel_wr_b(rel_wr_b), .i_rel_data(rel_data), .i_chan_cfg(chan_cfg),
		.i_staggered(staggered), .i_wr_en(wr_en), .i_wr_chan(wr_chan), .i_wr_data(wr_data),
		.i_pin(pin_in), .o_pin(o_pin), .o_pin_oe(o_pin_oe), .o_chan_value(o_chan_value),
		.o_irq(o_irq), .o_count_a(o_count_a), .o_count_b(o_count_b)
	);

	mcc_pin_model pin_model_inst (
		.i_mclk(i_mclk), .i_pin_out(o_pin), .i_pin_oe(o_pin_oe),
		.o_pin(pin_in), .o_ext_a(ext_a), .o_ext_b(ext_b)
	);

	initial begin
		i_mclk = 1'h0;
		forever #2 i_mclk = ~i_mclk;
	end

	task automatic end_sim();
		if (num_errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	// Whole run is about 66k cycles, mostly waiting for timer b to wrap
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			num_errors++;
			end_sim();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] ch, input logic [15:0] v);
		@(posedge i_mclk);
		wr_en   <= 1'h1;
		wr_chan <= ch;
		wr_data <= v;
		@(posedge i_mclk);
		wr_en   <= 1'h0;
	endtask : wr

	task automatic wait_b(input logic [15:0] v);
		int n;
		n = 0;
		// Off the edge, so a count changing in this time step is not misread
		#1;
		while (o_count_b !== v && n < 70000) begin
			@(posedge i_mclk);
			#1 n++;
		end
	endtask : wait_b

	task automatic run_row(input int ch);
		mcc_row_t    r;
		logic [15:0] v;
		int          n;
		r = ROWS[ch];
		@(posedge i_mclk);
		if (r.cap) begin
			// Raise the pin under the old setting so only the fall is new
			if (!r.rise) begin
				pin_model_inst.set_pin(ch, 1'h1);
				@(posedge i_mclk);
			end
			chan_cfg[ch] <= '{1'h1, 1'h0, r.es, mcc_pkg::MCC_CMP_IRQ_MULTI, 1'h0};
			pin_model_inst.set_pin(ch, r.rise);
			#1 v = o_count_a;
			@(posedge i_mclk);
			#1 chk(16'(o_irq[ch]), 16'(r.eirq));
			if (r.eirq)
				chk(o_chan_value[ch], v);
			@(posedge i_mclk);
			#1 chk(16'(o_irq[ch]), 16'h0000);
		end else begin
			chan_cfg[ch] <= '{1'h0, 1'h0, 2'h0, r.cm, 1'h0};
			#1 v = o_count_a + 16'h0010;
			wr(4'(ch), v);
			n = 0;
			while (o_count_a !== v && n < 64) begin
				@(posedge i_mclk);
				#1 n++;
			end
			// Match effect lands one edge after the count reaches v
			@(posedge i_mclk);
			#1 chk(16'(o_irq[ch]), 16'(r.eirq));
			chk(16'(o_pin[ch]), 16'(r.epin));
			chk(16'(o_pin_oe[ch]), 16'(r.epin));
		end
	endtask : run_row

	initial begin
		logic [15:0] c0;
		logic        p7;
		int          n11;
		int          n12;
		int          tog;
		int          ns;
		resetn   = 1'h0;
		cfg_a    = '0;
		cfg_b    = '0;
		gp_ovf   = 1'h0;
		rel_wr_b = 1'h0;
		rel_wr_a = 1'h0;
		staggered = 1'h0;
		rel_data = 16'h0000;
		wr_en    = 1'h0;
		wr_chan  = 4'h0;
		wr_data  = 16'h0000;
		for (int i = 0; i < 16; i++)
			chan_cfg[i] = '{1'h1, 1'h0, 2'h0, mcc_pkg::MCC_CMP_IRQ_MULTI, 1'h0};
		repeat (2) @(posedge i_mclk);
		resetn <= 1'h1;
		@(posedge i_mclk);
		#1 chk(o_irq | o_pin_oe | o_count_a | o_chan_value[0], 16'h0000);
		@(posedge i_mclk);
		rel_data <= 16'hFFF0;
		rel_wr_b <= 1'h1;
		rel_wr_a <= 1'h1;
		cfg_a    <= '{1'h1, mcc_pkg::MCC_SRC_PRESC, 3'h0};
		cfg_b    <= '{1'h1, mcc_pkg::MCC_SRC_PRESC, 3'h0};
		@(posedge i_mclk);
		rel_wr_b <= 1'h0;
		rel_wr_a <= 1'h0;
		for (int i = 0; i < 10; i++)
			run_row(i);
		// Count sources of timer a
		@(posedge i_mclk);
		cfg_a <= '{1'h1, mcc_pkg::MCC_SRC_GP_OVF, 3'h0};
		repeat (3) @(posedge i_mclk);
		#1 c0 = o_count_a;
		repeat (5) begin
			@(posedge i_mclk);
			gp_ovf <= 1'h1;
			@(posedge i_mclk);
			gp_ovf <= 1'h0;
		end
		repeat (2) @(posedge i_mclk);
		#1 chk(o_count_a - c0, 16'h0005);
		@(posedge i_mclk);
		cfg_a <= '{1'h1, mcc_pkg::MCC_SRC_EXT, 3'h0};
		repeat (3) @(posedge i_mclk);
		#1 c0 = o_count_a;
		pin_model_inst.ext_pulses(3);
		repeat (2) @(posedge i_mclk);
		#1 chk(o_count_a - c0, 16'h0003);
		@(posedge i_mclk);
		cfg_a <= '{1'h1, mcc_pkg::MCC_SRC_PRESC, 3'h2};
		repeat (3) @(posedge i_mclk);
		#1 c0 = o_count_a;
		repeat (32) @(posedge i_mclk);
		#1 chk(o_count_a - c0, 16'h0008);
		// Timer b wraps into a 16-cycle period
		wait_b(16'hFFFF);
		@(posedge i_mclk);
		#1 chk(o_count_b, 16'hFFF0);
		@(posedge i_mclk);
		chan_cfg[11] <= '{1'h0, 1'h1, 2'h0, mcc_pkg::MCC_CMP_IRQ_ONCE, 1'h0};
		chan_cfg[12] <= '{1'h0, 1'h1, 2'h0, mcc_pkg::MCC_CMP_IRQ_MULTI, 1'h1};
		chan_cfg[13] <= '{1'h0, 1'h1, 2'h0, mcc_pkg::MCC_CMP_SET_CLR, 1'h0};
		chan_cfg[7]  <= '{1'h0, 1'h1, 2'h0, mcc_pkg::MCC_CMP_DOUBLE, 1'h0};
		chan_cfg[15] <= '{1'h0, 1'h1, 2'h0, mcc_pkg::MCC_CMP_DOUBLE, 1'h0};
		wr(4'hB, 16'hFFF5);
		wr(4'hD, 16'hFFF8);
		wr(4'h7, 16'hFFF2);
		wr(4'hF, 16'hFFFA);
		// Single-event write lands after this period's match point
		wait_b(16'hFFF8);
		wr(4'hC, 16'hFFF5);
		wait_b(16'hFFF0);
		p7  = o_pin[7];
		n11 = 0;
		n12 = 0;
		tog = 0;
		repeat (48) begin
			@(posedge i_mclk);
			#1 if (o_irq[11] === 1'h1)
				n11++;
			if (o_irq[12] === 1'h1)
				n12++;
			if (o_pin[7] !== p7)
				tog++;
			p7 = o_pin[7];
			if (o_count_b === 16'hFFFC)
				chk(16'(o_pin[13]), 16'h0001);
			if (o_count_b === 16'hFFF4)
				chk(16'(o_pin[13]), 16'h0000);
		end
		chk(16'(n11), 16'h0003);
		chk(16'(n12), 16'h0001);
		chk(16'(tog), 16'h0006);
		// Staggered: a pin edge waits for its channel's slot, eight clocks at most
		@(posedge i_mclk);
		staggered <= 1'h1;
		pin_model_inst.set_pin(5, 1'h1);
		#1 ns = 0;
		while (o_irq[5] !== 1'h1 && ns < 12) begin
			c0 = o_count_a;
			@(posedge i_mclk);
			#1 ns++;
		end
		chk(16'(ns >= 1 && ns <= 8), 16'h0001);
		chk(o_chan_value[5], c0);
		end_sim();
	end
endmodule : tb
